/* rtl/sie_regs.vh */
// Register map, field positions and timing constants for the safety input evaluator
// What this block does
// - Selector variant takes one or two pins: single NO, double NO, NC/NO pair.
// - Fault output high in error state, low in on or off state.
// - Fault output only driven when fault_out_enable is set.
// - Pin counts active only after staying active longer than rise_filter_time.
// - With power_on_off_check, a valid off state is needed before first on.
// - With sync_window, all pins must turn active within the window.
// - After a window violation, all pins must go inactive before retrying.
// - With rest_interval, all pins stay inactive for the interval before on.
// - Custom variant drives on high only in on state.
// - Custom variant uses one to eight pins, each independently selectable.
// - Each pin compared against its own active and inactive level types.
// - Door variant uses two pins; on only when both show active signal.
// - Light curtain variant: two pins, on high only in on state.
// - E-stop variant: one or two pins, NC, double NC, or NC/NO pair.
// - Push button shares one pin: 1.5 ms driving, 0.5 ms sensing, repeating.
// - With indicator_in_enable, indicator_drive lights lamp during drive slots.
// - Push button on output high while pressed, low otherwise.
// - Push button turns on only after sensed high longer than filter time.
`ifndef SIE_REGS_VH
`define SIE_REGS_VH
// ============================================================
// Register byte offsets
`define SIE_CTRL_ADDR 4'h0
`define SIE_PINS_ADDR 4'h4
`define SIE_TIME_ADDR 4'h8
`define SIE_STAT_ADDR 4'hC
// ============================================================
// CTRL fields
`define SIE_CTRL_VAR_LSB 0
`define SIE_CTRL_VAR_MSB 2
`define SIE_CTRL_CNT_LSB 4
`define SIE_CTRL_CNT_MSB 7
`define SIE_CTRL_FAULT_EN 8
`define SIE_CTRL_POC_EN 9
`define SIE_CTRL_SYNC_EN 10
`define SIE_CTRL_REST_EN 11
`define SIE_CTRL_IND_EN 12
`define SIE_CTRL_RESET 32'h00000111
// PINS fields: enable, active type, inactive type bytes
`define SIE_PINS_SEL_LSB 0
`define SIE_PINS_ACT_LSB 8
`define SIE_PINS_INA_LSB 16
`define SIE_PINS_RESET 32'h0000FF01
// TIME fields: filter, window, rest in ms
`define SIE_TIME_FLT_LSB 0
`define SIE_TIME_WIN_LSB 8
`define SIE_TIME_RST_LSB 20
`define SIE_TIME_RESET 32'h0641C20A
// ============================================================
// Variants
`define SIE_VAR_CUSTOM 3'h0
`define SIE_VAR_SELECT 3'h1
`define SIE_VAR_DOOR 3'h2
`define SIE_VAR_CURTAIN 3'h3
`define SIE_VAR_ESTOP 3'h4
`define SIE_VAR_BUTTON 3'h5
// ============================================================
// Timing
`define SIE_CLK_HZ 20000000
`define SIE_TICK_US 1000
`define SIE_DRIVE_US 1500
`define SIE_SENSE_US 500
`define SIE_AXI_OKAY 2'h0
`define SIE_AXI_SLVERR 2'h2
`endif

/* rtl/sie_top.v */
// Safety input evaluator with AXI4-Lite register access
//
// Design decisions made here: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
`include "sie_regs.vh"
module sie_top #(
  parameter NPIN = 8,
  parameter TICK_CYC = (`SIE_CLK_HZ / 1000000) * `SIE_TICK_US,
  parameter DRIVE_CYC = (`SIE_CLK_HZ / 1000000) * `SIE_DRIVE_US,
  parameter SENSE_CYC = (`SIE_CLK_HZ / 1000000) * `SIE_SENSE_US
) (
  // Clock and reset
  input wire CLK,
  input wire RST_N,
  // AXI4-Lite write address
  input wire [3:0] AWADDR,
  input wire AWVALID,
  output reg AWREADY,
  // AXI4-Lite write data
  input wire [31:0] WDATA,
  input wire [3:0] WSTRB,
  input wire WVALID,
  output reg WREADY,
  // AXI4-Lite write response
  output reg [1:0] BRESP,
  output reg BVALID,
  input wire BREADY,
  // AXI4-Lite read
  input wire [3:0] ARADDR,
  input wire ARVALID,
  output reg ARREADY,
  output reg [31:0] RDATA,
  output reg [1:0] RRESP,
  output reg RVALID,
  input wire RREADY,
  // Field pins, pin 0 doubles as push button pin
  input wire [NPIN-1:0] PIN_IN,
  output reg PIN_OUT,
  output reg PIN_OE,
  // Lamp request
  input wire INDICATOR_DRIVE,
  // Results
  output reg ON_OUT,
  output reg FAULT_OUT
);
  localparam ST_OFF = 2'h0;
  localparam ST_ON = 2'h1;
  localparam ST_ERR = 2'h2;
  localparam ST_WAIT = 2'h3;

  // ============================================================
  // Registers
  reg [31:0] ctrl;
  reg [31:0] pins;
  reg [31:0] timing;
  reg [1:0] state;
  reg [NPIN-1:0] act_f;
  reg [15:0] tick_cnt;
  reg tick;
  reg [15:0] pb_cnt;
  reg pb_sense;
  reg sensed;
  reg [9:0] rest_ms;
  reg [11:0] win_ms;
  reg win_run;
  reg off_seen;
  reg [7:0] flt_ms [0:NPIN-1];

  wire [2:0] variant = ctrl[`SIE_CTRL_VAR_MSB:`SIE_CTRL_VAR_LSB];
  wire [7:0] flt_set = timing[`SIE_TIME_FLT_LSB+7:`SIE_TIME_FLT_LSB];
  wire [11:0] win_set = timing[`SIE_TIME_WIN_LSB+11:`SIE_TIME_WIN_LSB];
  wire [9:0] rest_set = timing[`SIE_TIME_RST_LSB+9:`SIE_TIME_RST_LSB];
  wire [7:0] act_t = pins[`SIE_PINS_ACT_LSB+7:`SIE_PINS_ACT_LSB];
  wire [7:0] ina_t = pins[`SIE_PINS_INA_LSB+7:`SIE_PINS_INA_LSB];

  // Mask of used pins per variant
  function [7:0] use_mask;
    input [2:0] v;
    input [3:0] cnt;
    input [7:0] sel;
    begin
      case (v)
        `SIE_VAR_CUSTOM: use_mask = sel & ((8'h01 << cnt) - 8'h01);
        `SIE_VAR_SELECT, `SIE_VAR_ESTOP: use_mask = (cnt > 4'h1) ? 8'h03 : 8'h01;
        `SIE_VAR_DOOR, `SIE_VAR_CURTAIN: use_mask = 8'h03;
        default: use_mask = 8'h01;
      endcase
    end
  endfunction

  wire [7:0] used = use_mask(variant, ctrl[`SIE_CTRL_CNT_MSB:`SIE_CTRL_CNT_LSB],
    pins[`SIE_PINS_SEL_LSB+7:`SIE_PINS_SEL_LSB]);
  wire [NPIN-1:0] lvl = (variant == `SIE_VAR_BUTTON) ?
    {{(NPIN-1){1'b0}}, sensed} : PIN_IN;
  wire [NPIN-1:0] is_act;
  wire [NPIN-1:0] is_ina;
  wire [NPIN-1:0] filt_ok;

  // ============================================================
  // Per-pin classification and rise filter
  genvar g;
  generate
    for (g = 0; g < NPIN; g = g + 1) begin : g_pin
      assign is_act[g] = (lvl[g] == act_t[g]);
      assign is_ina[g] = (lvl[g] == ina_t[g]);
      assign filt_ok[g] = act_f[g] | ~used[g];
      always @(posedge CLK) begin
        if (!RST_N) begin
          flt_ms[g] <= 8'h00;
          act_f[g] <= 1'b0;
        end else if (!is_act[g]) begin
          flt_ms[g] <= 8'h00;
          act_f[g] <= 1'b0;
        end else if (tick && !act_f[g]) begin
          if (flt_ms[g] >= flt_set)
            act_f[g] <= 1'b1;
          else
            flt_ms[g] <= flt_ms[g] + 8'h01;
        end
      end
    end
  endgenerate

  wire all_act = &filt_ok;
  wire any_raw_act = |(is_act & used[NPIN-1:0]);
  wire all_ina = &(is_ina | ~used[NPIN-1:0]);
  wire bad_lvl = |(~is_act & ~is_ina & used[NPIN-1:0]);
  wire rest_ok = !ctrl[`SIE_CTRL_REST_EN] || (rest_ms >= rest_set);
  wire win_bad = ctrl[`SIE_CTRL_SYNC_EN] && win_run && (win_ms > win_set);

  // ============================================================
  // 1 ms tick and push button slots
  always @(posedge CLK) begin
    if (!RST_N) begin
      tick_cnt <= 16'h0000;
      tick <= 1'b0;
    end else begin
      tick <= (tick_cnt == TICK_CYC[15:0] - 16'h0001);
      tick_cnt <= (tick_cnt == TICK_CYC[15:0] - 16'h0001) ? 16'h0000 : tick_cnt + 16'h0001;
    end
  end

  always @(posedge CLK) begin
    if (!RST_N) begin
      // Parked at the end of a sense slot so the first drive slot is whole
      pb_cnt <= SENSE_CYC[15:0] - 16'h0001;
      pb_sense <= 1'b1;
      sensed <= 1'b0;
      PIN_OUT <= 1'b0;
      PIN_OE <= 1'b0;
    end else if (variant == `SIE_VAR_BUTTON) begin
      if (!pb_sense && pb_cnt == DRIVE_CYC[15:0] - 16'h0001) begin
        pb_sense <= 1'b1;
        pb_cnt <= 16'h0000;
      end else if (pb_sense && pb_cnt == SENSE_CYC[15:0] - 16'h0001) begin
        pb_sense <= 1'b0;
        pb_cnt <= 16'h0000;
        sensed <= PIN_IN[0];
      end else begin
        pb_cnt <= pb_cnt + 16'h0001;
      end
      // Lamp only when enabled, never while sensing
      PIN_OE <= !(!pb_sense && pb_cnt == DRIVE_CYC[15:0] - 16'h0001) &&
        !(pb_sense && pb_cnt != SENSE_CYC[15:0] - 16'h0001);
      PIN_OUT <= ctrl[`SIE_CTRL_IND_EN] & INDICATOR_DRIVE &
        !(!pb_sense && pb_cnt == DRIVE_CYC[15:0] - 16'h0001) &&
        !(pb_sense && pb_cnt != SENSE_CYC[15:0] - 16'h0001);
    end else begin
      pb_cnt <= SENSE_CYC[15:0] - 16'h0001;
      pb_sense <= 1'b1;
      sensed <= 1'b0;
      PIN_OE <= 1'b0;
      PIN_OUT <= 1'b0;
    end
  end

  // ============================================================
  // Rest and simultaneity timers
  always @(posedge CLK) begin
    if (!RST_N) begin
      rest_ms <= 10'h000;
      win_ms <= 12'h000;
      win_run <= 1'b0;
    end else begin
      // A finished rest is held through the rise filter, a short one is lost
      if (state == ST_ON)
        rest_ms <= 10'h000;
      else if (all_ina) begin
        if (tick && rest_ms != 10'h3FF)
          rest_ms <= rest_ms + 10'h001;
      end else if (rest_ms < rest_set)
        rest_ms <= 10'h000;
      if (!any_raw_act || state != ST_OFF) begin
        win_run <= 1'b0;
        win_ms <= 12'h000;
      end else begin
        win_run <= 1'b1;
        if (tick && win_ms != 12'hFFF)
          win_ms <= win_ms + 12'h001;
      end
    end
  end

  // ============================================================
  // Evaluation state machine
  always @(posedge CLK) begin
    if (!RST_N) begin
      state <= ST_OFF;
      off_seen <= 1'b0;
      ON_OUT <= 1'b0;
      FAULT_OUT <= 1'b0;
    end else begin
      if (all_ina)
        off_seen <= 1'b1;
      case (state)
        ST_OFF: begin
          if (bad_lvl && variant != `SIE_VAR_BUTTON)
            state <= ST_ERR;
          else if (win_bad)
            state <= (variant == `SIE_VAR_CUSTOM) ? ST_WAIT : ST_ERR;
          else if (all_act && rest_ok &&
              (off_seen || !ctrl[`SIE_CTRL_POC_EN]))
            state <= ST_ON;
        end
        ST_ON: begin
          if (bad_lvl && variant != `SIE_VAR_BUTTON)
            state <= ST_ERR;
          else if (!all_act)
            state <= ST_OFF;
        end
        ST_WAIT, ST_ERR: begin
          if (all_ina)
            state <= ST_OFF;
        end
        default: state <= ST_OFF;
      endcase
      ON_OUT <= (state == ST_ON);
      FAULT_OUT <= ctrl[`SIE_CTRL_FAULT_EN] && (state == ST_ERR);
    end
  end

  // ============================================================
  // AXI4-Lite slave: write path
  reg aw_got;
  reg w_got;
  reg [3:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  wire do_wr = aw_got && w_got && !BVALID;

  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] st;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1)
        if (st[i])
          merge[i*8 +: 8] = nw[i*8 +: 8];
    end
  endfunction

  always @(posedge CLK) begin
    if (!RST_N) begin
      AWREADY <= 1'b0;
      WREADY <= 1'b0;
      BVALID <= 1'b0;
      BRESP <= `SIE_AXI_OKAY;
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr <= 4'h0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      ctrl <= `SIE_CTRL_RESET;
      pins <= `SIE_PINS_RESET;
      timing <= `SIE_TIME_RESET;
    end else begin
      AWREADY <= !aw_got && !AWREADY && AWVALID;
      WREADY <= !w_got && !WREADY && WVALID;
      if (AWVALID && AWREADY) begin
        aw_got <= 1'b1;
        aw_addr <= AWADDR;
      end
      if (WVALID && WREADY) begin
        w_got <= 1'b1;
        w_data <= WDATA;
        w_strb <= WSTRB;
      end
      if (do_wr) begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        BVALID <= 1'b1;
        BRESP <= `SIE_AXI_OKAY;
        case (aw_addr)
          `SIE_CTRL_ADDR: ctrl <= merge(ctrl, w_data, w_strb);
          `SIE_PINS_ADDR: pins <= merge(pins, w_data, w_strb);
          `SIE_TIME_ADDR: timing <= merge(timing, w_data, w_strb);
          `SIE_STAT_ADDR: BRESP <= `SIE_AXI_OKAY;
          default: BRESP <= `SIE_AXI_SLVERR;
        endcase
      end else if (BVALID && BREADY) begin
        BVALID <= 1'b0;
      end
    end
  end

  // ============================================================
  // AXI4-Lite slave: read path
  always @(posedge CLK) begin
    if (!RST_N) begin
      ARREADY <= 1'b0;
      RVALID <= 1'b0;
      RDATA <= 32'h00000000;
      RRESP <= `SIE_AXI_OKAY;
    end else begin
      ARREADY <= !ARREADY && !RVALID && ARVALID;
      if (ARVALID && ARREADY) begin
        RVALID <= 1'b1;
        RRESP <= `SIE_AXI_OKAY;
        case (ARADDR)
          `SIE_CTRL_ADDR: RDATA <= ctrl;
          `SIE_PINS_ADDR: RDATA <= pins;
          `SIE_TIME_ADDR: RDATA <= timing;
          `SIE_STAT_ADDR: RDATA <= {16'h0000, act_f[7:0], 3'h0, off_seen,
            2'h0, state};
          default: begin
            RDATA <= 32'h00000000;
            RRESP <= `SIE_AXI_SLVERR;
          end
        endcase
      end else if (RVALID && RREADY) begin
        RVALID <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

/* sim/sie_asserts.sv */
// Port checker for the safety input evaluator
`timescale 1ns/100ps
`default_nettype none
module sie_asserts #(
  parameter DRIVE_CYC = 30
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // Register bus
  input wire logic AWVALID,
  input wire logic AWREADY,
  input wire logic BVALID,
  input wire logic BREADY,
  input wire logic [1:0] BRESP,
  input wire logic ARVALID,
  input wire logic ARREADY,
  input wire logic RVALID,
  input wire logic RREADY,
  input wire logic [31:0] RDATA,
  // Field side and results
  input wire logic PIN_OUT,
  input wire logic PIN_OE,
  input wire logic ON_OUT,
  input wire logic FAULT_OUT
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  // ============
  // Drive slot length, counted since a repetition count would be too long
  logic [15:0] oe_len;
  always @(posedge CLK) begin
    if (!RST_N || !PIN_OE) oe_len <= 16'h0000;
    else oe_len <= oe_len + 16'h0001;
  end
  // ============
  // Properties
  sequence s_aw_taken; AWVALID && AWREADY; endsequence
  sequence s_resp_due; ##[1:4] BVALID; endsequence
  property p_wr_ans; s_aw_taken |-> s_resp_due; endproperty
  property p_rd_ans; ARVALID && ARREADY |-> ##[1:4] RVALID; endproperty
  property p_bhold; BVALID && !BREADY |=> BVALID && $stable(BRESP); endproperty
  property p_rhold; RVALID && !RREADY |=> RVALID && $stable(RDATA); endproperty
  property p_aw_pulse; AWREADY |=> !AWREADY; endproperty
  property p_excl; !(ON_OUT && FAULT_OUT); endproperty
  property p_lamp; PIN_OUT |-> PIN_OE; endproperty
  property p_drive; $fell(PIN_OE) |-> oe_len == DRIVE_CYC; endproperty
  a_wr_ans: assert property (p_wr_ans) else $error("write response late");
  a_rd_ans: assert property (p_rd_ans) else $error("read data late");
  a_bhold: assert property (p_bhold) else $error("write response dropped");
  a_rhold: assert property (p_rhold) else $error("read data dropped");
  a_aw_pulse: assert property (p_aw_pulse) else $error("awready not a pulse");
  a_excl: assert property (p_excl) else $error("on and fault together");
  a_lamp: assert property (p_lamp) else $error("lamp outside drive slot");
  a_drive: assert property (p_drive) else $error("drive slot length wrong");
endmodule
bind sie_top sie_asserts #(.DRIVE_CYC(DRIVE_CYC)) u_chk (.CLK(CLK), .RST_N(RST_N),
  .AWVALID(AWVALID), .AWREADY(AWREADY), .BVALID(BVALID), .BREADY(BREADY), .BRESP(BRESP),
  .ARVALID(ARVALID), .ARREADY(ARREADY), .RVALID(RVALID), .RREADY(RREADY), .RDATA(RDATA),
  .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE), .ON_OUT(ON_OUT), .FAULT_OUT(FAULT_OUT));
`default_nettype wire

/* sim/sie_field.sv */
// Field devices wired to the input pins
`timescale 1ns/100ps
`default_nettype none
module sie_field (
  // Device levels
  input wire logic [7:0] level,
  // Shared button pin drive
  input wire logic pin_out,
  input wire logic pin_oe,
  // Pins seen by the block
  output logic [7:0] pin_in
);
  // Lamp drive shows on the shared pin, so drive slots must not be sensed
  assign pin_in = {level[7:1], pin_oe ? pin_out : level[0]};
endmodule
`default_nettype wire

/* sim/safety_input_evaluation_tb_top.sv */
// Self-checking bench for the safety input evaluator
`timescale 1ns/100ps
`default_nettype none
module safety_input_evaluation_tb_top;
  logic CLK, RST_N, AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY, seen, ind;
  logic ARVALID, ARREADY, RVALID, RREADY, PIN_OUT, PIN_OE, ON_OUT, FAULT_OUT;
  logic [3:0] AWADDR, ARADDR;
  logic [31:0] WDATA, RDATA;
  logic [1:0] BRESP, RRESP;
  logic [7:0] lvl, PIN_IN;
  integer bad_count = 0, compares = 0, i;
  sie_top #(.TICK_CYC(20), .DRIVE_CYC(30), .SENSE_CYC(10)) u_dut (.CLK(CLK), .RST_N(RST_N),
    .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(4'hF),
    .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY),
    .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP),
    .RVALID(RVALID), .RREADY(RREADY), .PIN_IN(PIN_IN), .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE),
    .INDICATOR_DRIVE(ind), .ON_OUT(ON_OUT), .FAULT_OUT(FAULT_OUT));
  sie_field u_fld (.level(lvl), .pin_out(PIN_OUT), .pin_oe(PIN_OE), .pin_in(PIN_IN));
  // ============
  // Shared tasks
  task end_of_test;
    begin
      if (bad_count == 0 && compares > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
    end
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    begin
      compares = compares + 1;
      if (g !== e) begin
        bad_count = bad_count + 1;
        $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
      end
    end
  endtask
  task ms(input integer n);
    repeat (n * 20) @(posedge CLK);
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d);
    begin
      AWADDR <= a; WDATA <= d; AWVALID <= 1'b1; WVALID <= 1'b1;
      @(posedge CLK);
      while (AWVALID || WVALID) begin
        if (AWREADY) AWVALID <= 1'b0;
        if (WREADY) WVALID <= 1'b0;
        @(posedge CLK);
      end
      while (!BVALID) @(posedge CLK);
      BREADY <= 1'b1;
      @(posedge CLK);
      BREADY <= 1'b0;
      chk(BRESP, 32'h0);
    end
  endtask
  task rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
    begin
      ARADDR <= a; ARVALID <= 1'b1;
      @(posedge CLK);
      while (!ARREADY) @(posedge CLK);
      ARVALID <= 1'b0;
      @(posedge CLK);
      while (!RVALID) @(posedge CLK);
      RREADY <= 1'b1;
      @(posedge CLK);
      RREADY <= 1'b0;
      chk(RDATA, ed);
      chk(RRESP, er);
    end
  endtask
  // ============
  // Scenarios
  task t_regs;
    begin
      rd(4'h0, 32'h00000111, 2'h0);
      rd(4'h4, 32'h0000FF01, 2'h0);
      rd(4'h8, 32'h0641C20A, 2'h0);
      rd(4'h2, 32'h0, 2'h2);
    end
  endtask
  task t_poc;
    begin
      wr(4'h4, 32'h00000303);
      wr(4'h8, 32'h00000002);
      wr(4'h0, 32'h00000320);
      ms(6); chk(ON_OUT, 1'b0);
      lvl <= 8'h00; ms(1); chk(FAULT_OUT, 1'b0);
      lvl <= 8'h03; repeat (30) @(posedge CLK); chk(ON_OUT, 1'b0);
      ms(3); chk(ON_OUT, 1'b1);
      lvl <= 8'h01; ms(1); chk(ON_OUT, 1'b0);
    end
  endtask
  task t_rest;
    begin
      wr(4'h8, 32'h00400002);
      wr(4'h0, 32'h00000B20);
      lvl <= 8'h00; ms(1); lvl <= 8'h03; ms(6); chk(ON_OUT, 1'b0);
      lvl <= 8'h00; ms(5); lvl <= 8'h03; ms(4); chk(ON_OUT, 1'b1);
    end
  endtask
  task t_win;
    for (i = 2; i >= 0; i = i - 1) begin
      wr(4'h8, 32'h00000301);
      wr(4'h0, (i == 2) ? 32'h00000522 : (i == 1) ? 32'h00000423 : 32'h00000420);
      lvl <= 8'h00; ms(2); lvl <= 8'h01; ms(6);
      chk(FAULT_OUT, i == 2);
      lvl <= 8'h03; ms(4); chk(ON_OUT, 1'b0);
      rd(4'hC, (i == 0) ? 32'h0000FF13 : 32'h0000FF12, 2'h0);
      lvl <= 8'h00; ms(2); chk(FAULT_OUT, 1'b0);
      lvl <= 8'h03; ms(4); chk(ON_OUT, 1'b1);
    end
  endtask
  task t_btn;
    begin
      lvl <= 8'h00; ind <= 1'b1; seen = 1'b0;
      wr(4'h8, 32'h00000002);
      wr(4'h0, 32'h00001005);
      repeat (120) begin
        @(posedge CLK);
        if (PIN_OE === 1'b1 && PIN_OUT === 1'b1) seen = 1'b1;
      end
      chk(seen, 1'b1);
      chk(ON_OUT, 1'b0);
      ind <= 1'b0; lvl <= 8'h01; ms(1); chk(ON_OUT, 1'b0);
      ms(8); chk(ON_OUT, 1'b1);
      lvl <= 8'h00; ms(4); chk(ON_OUT, 1'b0);
    end
  endtask
  // ============
  // Clock, watchdog and main sequence
  initial begin
    CLK = 1'b0;
    forever #25 CLK = ~CLK;
  end
  initial begin
    repeat (20000) @(posedge CLK);
    bad_count = bad_count + 1;
    end_of_test;
  end
  initial begin
    {RST_N, AWVALID, WVALID, BREADY, ARVALID, RREADY, ind} = 7'h00;
    AWADDR = 4'h0; ARADDR = 4'h0; WDATA = 32'h0; lvl = 8'h03;
    repeat (3) @(posedge CLK);
    RST_N <= 1'b1;
    @(posedge CLK);
    t_regs;
    t_poc;
    t_rest;
    t_win;
    t_btn;
    end_of_test;
  end
endmodule
`default_nettype wire
